// file: rtl/hhsc_ctrl.sv
// six-channel half-bridge serial control and diagnostic core
`timescale 1ns/1ns
`default_nettype none

// Operation
// - words are 16 bits, least significant bit first, both directions
// - serial input is sampled on each falling serial clock edge
// - select rising copies the shifted command into control registers
// - serial output released while select high, driven only while low
// - frame accepted only for a nonzero multiple of 16 clocks
// - status word shifts out while the command shifts in
// - longer frames pass earlier words through for daisy chaining
// - command bit 15 arms all-off on supply overvoltage
// - command bit 14 arms turn-off of an underloaded output
// - command bit 13 arms latch-off on overcurrent, else only limiting
// - bits 12..1 switch outputs; even bits high sides, odd low sides
// - command bit 0 clears latched fault flags
// - status bit 15 reports overvoltage or undervoltage supply fault
// - status bit 14 reports underload on any output
// - status bit 13 reports overload on any output
// - status bits 12..1 return present output states, command mapping
// - wake low enters sleep and loses all register contents
// - status bit 0 thermal warning latches until clear request
// - thermal warning bit appears on output as soon as select falls
// - armed overcurrent latches output off until clear or new on command
// - armed persistent underload latches only the offending output off
module hhsc_ctrl #(
   parameter int ULD_DELAY_CYC = hhsc_pkg::ULD_DELAY_CYC
) (
   // system clock and control
   input  wire logic                      ref_clk_i,
   input  wire logic                      sys_rst_i,
   input  wire logic                      clk_en_i,
   input  wire logic                      wake_i,
   // serial link
   input  wire logic                      sclk_i,
   input  wire logic                      chip_select_n_i,
   input  wire logic                      serial_in_i,
   output logic                           serial_out_o,
   output logic                           serial_out_oe_n_o,
   // supply and thermal monitors
   input  wire logic                      overvoltage_i,
   input  wire logic                      undervoltage_lockout_i,
   input  wire logic                      thermal_warning_i,
   // per-channel load monitors
   input  wire logic [hhsc_pkg::CH_N-1:0] overcurrent_hs_i,
   input  wire logic [hhsc_pkg::CH_N-1:0] overcurrent_ls_i,
   input  wire logic [hhsc_pkg::CH_N-1:0] underload_hs_i,
   input  wire logic [hhsc_pkg::CH_N-1:0] underload_ls_i,
   // drivers
   output logic [hhsc_pkg::CH_N-1:0]      high_side_drive_o,
   output logic [hhsc_pkg::CH_N-1:0]      low_side_drive_o
);

   localparam int UC_W = $clog2(ULD_DELAY_CYC + 1);
   localparam logic [UC_W-1:0] UC_MAX = UC_W'(ULD_DELAY_CYC);
   localparam int DN = hhsc_pkg::DRV_N;

   typedef struct packed {
      logic                           cs_m;
      logic                           cs_s;
      logic                           wake_m;
      logic                           wake_s;
      logic [hhsc_pkg::FLT_W-1:0]     flt_m;
      logic [hhsc_pkg::FLT_W-1:0]     flt_s;
      logic                           tog_m;
      logic                           tog_s;
      logic                           tog_seen;
      hhsc_pkg::hhsc_state_t          state;
      logic                           overvoltage_cutoff_arm;
      logic                           underload_cutoff_arm;
      logic                           overamp_cutoff_arm;
      logic [DN-1:0]                  drive_req;
      logic [DN-1:0]                  latch_off;
      logic                           supply_fault_flag;
      logic                           underload_flag;
      logic                           overload_flag;
      logic                           thermal_warning_flag;
      logic [DN-1:0][UC_W-1:0]        ul_cnt;
      logic [DN-1:0]                  drive_q;
      logic [hhsc_pkg::WORD_W-1:0]    status_q;
   } hhsc_core_t;

   hhsc_core_t q, n;

   logic [hhsc_pkg::WORD_W-1:0] link_word;
   logic                        link_valid;
   logic                        link_tog;
   logic                        link_so;

   hhsc_link u_link (
      .sclk_i          (sclk_i),
      .chip_select_n_i (chip_select_n_i),
      .serial_in_i     (serial_in_i),
      .sys_rst_i       (sys_rst_i),
      .status_i        (q.status_q),
      .serial_out_o    (link_so),
      .word_o          (link_word),
      .valid_o         (link_valid),
      .frame_tog_o     (link_tog)
   );

   always_comb begin
      logic          ov;
      logic          uv;
      logic          tw;
      logic [DN-1:0] oc;
      logic [DN-1:0] ul;
      logic          load_ok;
      logic [DN-1:0] cmd_drv;
      logic          cut_all;
      ov      = q.flt_s[hhsc_pkg::FLT_OV];
      uv      = q.flt_s[hhsc_pkg::FLT_UV];
      tw      = q.flt_s[hhsc_pkg::FLT_TW];
      oc      = q.flt_s[hhsc_pkg::FLT_OC_L +: DN];
      ul      = q.flt_s[hhsc_pkg::FLT_UL_L +: DN];
      load_ok = 1'b0;
      cmd_drv = link_word[hhsc_pkg::CMD_DRV_LSB +: DN];
      cut_all = 1'b0;
      n = q;
      if (clk_en_i) begin
         // pins from outside cross through two stages
         n.cs_m   = chip_select_n_i;
         n.cs_s   = q.cs_m;
         n.wake_m = wake_i;
         n.wake_s = q.wake_m;
         n.flt_m  = {overvoltage_i, undervoltage_lockout_i, thermal_warning_i,
                     hhsc_pkg::hhsc_interleave(overcurrent_hs_i, overcurrent_ls_i),
                     hhsc_pkg::hhsc_interleave(underload_hs_i, underload_ls_i)};
         n.flt_s  = q.flt_m;
         n.tog_m  = link_tog;
         n.tog_s  = q.tog_m;

         case (q.state)
            hhsc_pkg::HHSC_SLEEP: begin
               n.tog_seen = q.tog_s;
               if (q.wake_s) begin
                  n.state = hhsc_pkg::HHSC_IDLE;
               end
            end
            hhsc_pkg::HHSC_IDLE: begin
               if (!q.cs_s) begin
                  n.state = hhsc_pkg::HHSC_FRAME;
               end
            end
            hhsc_pkg::HHSC_FRAME: begin
               if (q.cs_s) begin
                  n.state = hhsc_pkg::HHSC_LOAD;
               end
            end
            hhsc_pkg::HHSC_LOAD: begin
               // a frame with no clocks leaves the toggle alone and loads nothing
               n.state = hhsc_pkg::HHSC_IDLE;
               if (q.tog_s != q.tog_seen) begin
                  n.tog_seen = q.tog_s;
                  load_ok    = link_valid;
               end
            end
            default: begin
               n.state = hhsc_pkg::HHSC_SLEEP;
            end
         endcase

         if (load_ok) begin
            n.overvoltage_cutoff_arm = link_word[hhsc_pkg::CMD_OV_ARM];
            n.underload_cutoff_arm   = link_word[hhsc_pkg::CMD_UL_ARM];
            n.overamp_cutoff_arm     = link_word[hhsc_pkg::CMD_OC_ARM];
            n.drive_req              = cmd_drv;
            n.latch_off              = q.latch_off & ~cmd_drv;
            if (link_word[hhsc_pkg::CMD_CLR]) begin
               n.latch_off            = '0;
               n.supply_fault_flag    = 1'b0;
               n.underload_flag       = 1'b0;
               n.overload_flag        = 1'b0;
               n.thermal_warning_flag = 1'b0;
            end
         end

         // events come after the clear so a coincident event survives it
         for (int i = 0; i < DN; i++) begin
            if (ul[i] && q.drive_q[i]) begin
               n.ul_cnt[i] = (q.ul_cnt[i] == UC_MAX) ? UC_MAX : UC_W'(q.ul_cnt[i] + 1'b1);
            end else begin
               n.ul_cnt[i] = '0;
            end
            if (q.ul_cnt[i] == UC_MAX) begin
               n.underload_flag = 1'b1;
               if (q.underload_cutoff_arm) begin
                  n.latch_off[i] = 1'b1;
               end
            end
            if (oc[i] && q.drive_q[i]) begin
               n.overload_flag = 1'b1;
               if (q.overamp_cutoff_arm) begin
                  n.latch_off[i] = 1'b1;
               end
            end
         end
         if (ov || uv) begin
            n.supply_fault_flag = 1'b1;
         end
         if (tw) begin
            n.thermal_warning_flag = 1'b1;
         end

         // overvoltage cut is not latched; outputs return once it clears
         cut_all   = uv || (q.overvoltage_cutoff_arm && ov);
         n.drive_q = cut_all ? hhsc_pkg::DRIVE_RST : (q.drive_req & ~q.latch_off);

         // frozen during a frame so the shifted word stays coherent
         if (q.state != hhsc_pkg::HHSC_FRAME) begin
            n.status_q = {q.supply_fault_flag, q.underload_flag, q.overload_flag,
                          q.drive_q, q.thermal_warning_flag};
         end

         if (!q.wake_s) begin
            n.state = hhsc_pkg::HHSC_SLEEP;
         end
         if (n.state == hhsc_pkg::HHSC_SLEEP) begin
            n.overvoltage_cutoff_arm = hhsc_pkg::ARM_RST[2];
            n.underload_cutoff_arm   = hhsc_pkg::ARM_RST[1];
            n.overamp_cutoff_arm     = hhsc_pkg::ARM_RST[0];
            n.drive_req              = hhsc_pkg::DRIVE_RST;
            n.latch_off              = hhsc_pkg::DRIVE_RST;
            n.drive_q                = hhsc_pkg::DRIVE_RST;
            n.supply_fault_flag      = 1'b0;
            n.underload_flag         = 1'b0;
            n.overload_flag          = 1'b0;
            n.thermal_warning_flag   = 1'b0;
            n.ul_cnt                 = '0;
            n.status_q               = hhsc_pkg::STATUS_RST;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // output stage must follow select with no clock, hence straight from the pin
   assign serial_out_oe_n_o = chip_select_n_i;
   assign serial_out_o      = link_so;
   assign high_side_drive_o = hhsc_pkg::hhsc_side(q.drive_q, 1'b1);
   assign low_side_drive_o  = hhsc_pkg::hhsc_side(q.drive_q, 1'b0);

endmodule

`default_nettype wire

// file: rtl/hhsc_pkg.sv
// constants, types and helpers shared by the half-bridge serial control block
package hhsc_pkg;

   // serial word layout
   localparam int WORD_W    = 16;
   localparam int CNT_W     = 4;
   localparam int CH_N      = 6;
   localparam int DRV_N     = 12;

   // command word fields
   localparam int CMD_OV_ARM  = 15;
   localparam int CMD_UL_ARM  = 14;
   localparam int CMD_OC_ARM  = 13;
   localparam int CMD_DRV_LSB = 1;
   localparam int CMD_CLR     = 0;

   // status word fields
   localparam int STA_SUPPLY    = 15;
   localparam int STA_UNDERLOAD = 14;
   localparam int STA_OVERLOAD  = 13;
   localparam int STA_DRV_LSB   = 1;
   localparam int STA_THERMAL   = 0;

   // fault input bundle layout after synchronising
   localparam int FLT_W    = 27;
   localparam int FLT_OV   = 26;
   localparam int FLT_UV   = 25;
   localparam int FLT_TW   = 24;
   localparam int FLT_OC_L = 12;
   localparam int FLT_UL_L = 0;

   // values after reset
   localparam logic [DRV_N-1:0]  DRIVE_RST  = 12'h000;
   localparam logic [2:0]        ARM_RST    = 3'h0;
   localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;
   localparam logic [CNT_W-1:0]  CNT_RST    = 4'h0;

   // underload filter time and its cycle count
   localparam int REF_CLK_KHZ   = 10000;
   localparam int ULD_DELAY_US  = 200;
   localparam int ULD_DELAY_CYC = (ULD_DELAY_US * REF_CLK_KHZ + 999) / 1000;

   // gray-coded along sleep -> idle -> frame -> load
   typedef enum logic [1:0] {
      HHSC_SLEEP = 2'b00,
      HHSC_IDLE  = 2'b01,
      HHSC_FRAME = 2'b11,
      HHSC_LOAD  = 2'b10
   } hhsc_state_t;

   // channel j: high side at word bit 2j+1, low side at 2j (relative to drive lsb)
   function automatic logic [DRV_N-1:0] hhsc_interleave(input logic [CH_N-1:0] hs,
                                                        input logic [CH_N-1:0] ls);
      logic [DRV_N-1:0] r;
      r = '0;
      for (int j = 0; j < CH_N; j++) begin
         r[2*j+1] = hs[j];
         r[2*j]   = ls[j];
      end
      return r;
   endfunction

   function automatic logic [CH_N-1:0] hhsc_side(input logic [DRV_N-1:0] v,
                                                 input logic             high);
      logic [CH_N-1:0] r;
      r = '0;
      for (int j = 0; j < CH_N; j++) begin
         r[j] = high ? v[2*j+1] : v[2*j];
      end
      return r;
   endfunction

endpackage

// file: rtl/hhsc_link.sv
// serial shift path running on the host's serial clock
`timescale 1ns/1ns
`default_nettype none

module hhsc_link (
   // link clock and frame
   input  wire logic                        sclk_i,
   input  wire logic                        chip_select_n_i,
   input  wire logic                        serial_in_i,
   input  wire logic                        sys_rst_i,
   // status from core, quasi-static while selected
   input  wire logic [hhsc_pkg::WORD_W-1:0] status_i,
   // towards pin and core
   output logic                             serial_out_o,
   output logic [hhsc_pkg::WORD_W-1:0]      word_o,
   output logic                             valid_o,
   output logic                             frame_tog_o
);

   typedef struct packed {
      logic [hhsc_pkg::WORD_W-1:0] sr;
      logic [hhsc_pkg::CNT_W-1:0]  cnt;
      logic                        seen;
      logic                        any;
   } hhsc_frm_t;

   typedef struct packed {
      logic [hhsc_pkg::WORD_W-1:0] word;
      logic                        valid;
      logic                        tog;
   } hhsc_res_t;

   hhsc_frm_t f_q, f_d;
   hhsc_res_t r_q, r_d;
   logic      rose_q;
   logic      so_q;
   logic      out_bit;

   always_comb begin
      f_d = f_q;
      r_d = r_q;
      f_d.sr  = {serial_in_i, f_q.sr[hhsc_pkg::WORD_W-1:1]};
      f_d.cnt = hhsc_pkg::CNT_W'(f_q.cnt + 4'h1);
      if (f_q.cnt == 4'hF) begin
         f_d.seen = 1'b1;
      end
      f_d.any = 1'b1;
      if (!f_q.any) begin
         r_d.tog = ~r_q.tog;
      end
      // result kept outside the frame reset so the core can read it after deselect
      r_d.word  = f_d.sr;
      r_d.valid = f_d.seen && (f_d.cnt == hhsc_pkg::CNT_RST);
   end

   // first word is the status, later words pass through from serial input
   always_comb begin
      out_bit = f_q.seen ? f_q.sr[0] : status_i[f_q.cnt];
   end

   // system reset as well, else the counter is unknown until the first deselect
   always_ff @(negedge sclk_i or posedge chip_select_n_i or posedge sys_rst_i) begin
      if (chip_select_n_i || sys_rst_i) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   always_ff @(negedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r_q <= '0;
      end else if (!chip_select_n_i) begin
         r_q <= r_d;
      end
   end

   always_ff @(posedge sclk_i or posedge chip_select_n_i or posedge sys_rst_i) begin
      if (chip_select_n_i || sys_rst_i) begin
         rose_q <= 1'b0;
         so_q   <= 1'b0;
      end else begin
         rose_q <= 1'b1;
         so_q   <= out_bit;
      end
   end

   // before any rising edge the thermal bit shows at once
   assign serial_out_o = rose_q ? so_q : status_i[hhsc_pkg::STA_THERMAL];
   assign word_o       = r_q.word;
   assign valid_o      = r_q.valid;
   assign frame_tog_o  = r_q.tog;

endmodule

`default_nettype wire

// file: tb/hhsc_monitor.sv
// assertion checker for the half-bridge serial control top
`timescale 1ns/1ns
`default_nettype none

module hhsc_monitor #(
   parameter int ULD_DELAY_CYC = 8
) (
   // clock, reset, link
   input wire logic       ref_clk_i,
   input wire logic       sys_rst_i,
   input wire logic       wake_i,
   input wire logic       sclk_i,
   input wire logic       chip_select_n_i,
   input wire logic       serial_in_i,
   input wire logic       serial_out_o,
   input wire logic       serial_out_oe_n_o,
   // monitors and drivers
   input wire logic       overvoltage_i,
   input wire logic       undervoltage_lockout_i,
   input wire logic [5:0] overcurrent_hs_i,
   input wire logic [5:0] overcurrent_ls_i,
   input wire logic [5:0] underload_hs_i,
   input wire logic [5:0] underload_ls_i,
   input wire logic [5:0] high_side_drive_o,
   input wire logic [5:0] low_side_drive_o
);
   logic [11:0] drv;
   logic [11:0] drv_q;
   logic        cs_q;
   logic [3:0]  since_q;
   logic [15:0] hist_q;
   logic [4:0]  nfall_q;
   logic        quiet;

   assign drv = {high_side_drive_o, low_side_drive_o};
   assign quiet = wake_i && !overvoltage_i && !undervoltage_lockout_i
                  && !(|{overcurrent_hs_i, overcurrent_ls_i, underload_hs_i, underload_ls_i});

   // cycles since anything that may legally switch a drive on
   always_ff @(posedge ref_clk_i) begin
      drv_q <= drv;
      cs_q  <= chip_select_n_i;
      if (sys_rst_i || !quiet || (chip_select_n_i && !cs_q)) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
   end

   // input history per frame, cleared when the host deselects
   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         hist_q  <= 16'h0000;
         nfall_q <= 5'h00;
      end else begin
         hist_q <= {hist_q[14:0], serial_in_i};
         if (nfall_q != 5'h10) nfall_q <= nfall_q + 5'h01;
      end
   end

   a_oe_tracks_sel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      serial_out_oe_n_o == chip_select_n_i) else $error("enable does not follow select");
   a_oe_on_edges: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
      !serial_out_oe_n_o) else $error("output released during a clock pulse");
   a_reset_off: assert property (@(posedge ref_clk_i)
      sys_rst_i |=> drv == 12'h000) else $error("drive on after reset");
   a_sleep_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (!wake_i) [*4] |=> drv == 12'h000) else $error("drive on while asleep");
   a_uv_all_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      undervoltage_lockout_i [*4] |=> drv == 12'h000) else $error("drive on in lockout");
   a_drv_hold_frame: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (quiet && !chip_select_n_i) [*8] |=> $stable(drv)) else $error("drive moved in frame");
   a_drv_on_cause: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (|(drv & ~drv_q)) |-> since_q <= 4'hA) else $error("drive on without command");
   a_daisy_pass: assert property (@(negedge sclk_i) disable iff (chip_select_n_i)
      nfall_q == 5'h10 |-> serial_out_o == hist_q[15]) else $error("chain bit wrong");

   c_frame_end: cover property (@(posedge ref_clk_i) $rose(chip_select_n_i));
   c_sleep: cover property (@(posedge ref_clk_i) (!wake_i) [*4]);
   c_chain: cover property (@(negedge sclk_i) nfall_q == 5'h10);
endmodule

bind hhsc_ctrl hhsc_monitor #(.ULD_DELAY_CYC(ULD_DELAY_CYC)) u_mon (
   .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .wake_i(wake_i), .sclk_i(sclk_i),
   .chip_select_n_i(chip_select_n_i), .serial_in_i(serial_in_i),
   .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o),
   .overvoltage_i(overvoltage_i), .undervoltage_lockout_i(undervoltage_lockout_i),
   .overcurrent_hs_i(overcurrent_hs_i), .overcurrent_ls_i(overcurrent_ls_i),
   .underload_hs_i(underload_hs_i), .underload_ls_i(underload_ls_i),
   .high_side_drive_o(high_side_drive_o), .low_side_drive_o(low_side_drive_o));
`default_nettype wire

// file: tb/hhsc_host.sv
// serial bus master model standing in for the host controller
`timescale 1ns/1ns
`default_nettype none

module hhsc_host (
   // towards the device
   output logic     sclk_o,
   output logic     cs_n_o,
   output logic     si_o,
   // from the device
   input wire logic so_i
);
   // idle levels follow the pin pulls: select high, clock and data low
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end

   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0000_0000;
      #7 cs_n_o = 1'b0;
      #400;
      // data moves 5 ns after the falling edge, never in the step that samples it
      for (int k = 0; k < n; k++) begin
         si_o = tx[k];
         #10 sclk_o = 1'b1;
         #15 rx[k] = so_i;
         sclk_o = 1'b0;
         #5;
      end
      si_o = 1'b0;
      #10 cs_n_o = 1'b1;
      #1000;
   endtask

   // select only, no clock: the first status bit must already be there
   task automatic peek(output logic b);
      #7 cs_n_o = 1'b0;
      #40 b = so_i;
      cs_n_o = 1'b1;
      #1000;
   endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the half-bridge serial control block
`timescale 1ns/1ns
`default_nettype none

module tb;
   logic        ref_clk_i = 1'b0;
   logic        sys_rst_i = 1'b0;
   logic        wake_i    = 1'b1;
   logic [26:0] flt       = 27'h0;
   logic        sclk;
   logic        cs_n;
   logic        si;
   logic        so;
   logic        oe_n;
   logic [5:0]  hs;
   logic [5:0]  ls;
   wire         so_pin;
   logic [11:0] m_drv;
   logic [2:0]  m_flg;
   logic        m_tw;
   logic        b;
   logic [31:0] rx_dump;
   int          mismatches = 0;
   int          cmp_count  = 0;
   int          bad[4]     = '{15, 0, 17, 31};

   always #50 ref_clk_i = ~ref_clk_i;
   assign so_pin = oe_n ? 1'bz : so;

   hhsc_ctrl #(.ULD_DELAY_CYC(8)) dut (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .wake_i(wake_i),
      .sclk_i(sclk), .chip_select_n_i(cs_n), .serial_in_i(si), .serial_out_o(so),
      .serial_out_oe_n_o(oe_n), .overvoltage_i(flt[26]), .undervoltage_lockout_i(flt[25]),
      .thermal_warning_i(flt[24]), .overcurrent_hs_i(flt[23:18]),
      .overcurrent_ls_i(flt[17:12]), .underload_hs_i(flt[11:6]), .underload_ls_i(flt[5:0]),
      .high_side_drive_o(hs), .low_side_drive_o(ls));
   hhsc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_pin));

   function automatic logic [15:0] pins();
      pins = 16'h0000;
      for (int j = 0; j < 6; j++) begin
         pins[2*j+1] = hs[j];
         pins[2*j]   = ls[j];
      end
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // one frame through the host; the model follows only whole words
   task automatic frame(input logic [31:0] tx, input int n);
      logic [31:0] rx;
      logic [15:0] cmd;
      host.xfer(tx, n, rx);
      if (n >= 16) chk(rx[15:0], {m_flg, m_drv, m_tw}, "status");
      if (n == 32) chk(rx[31:16], tx[15:0], "chain");
      if (n != 0 && n % 16 == 0) begin
         cmd = tx[n-16 +: 16];
         m_drv = cmd[12:1];
         if (cmd[0]) {m_flg, m_tw} = 4'h0;
      end
      chk(pins(), {4'h0, m_drv}, "drives");
   endtask

   task automatic fault(input int bit_idx, input int n);
      flt[bit_idx] <= 1'b1;
      cyc(n);
      flt[bit_idx] <= 1'b0;
      cyc(6);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      // a real rising edge, so the link's asynchronously reset flops leave unknown
      sys_rst_i <= 1'b1;
      void'($urandom(32'h976A0F8F));
      {m_flg, m_drv, m_tw} = 16'h0000;
      cyc(10);
      sys_rst_i <= 1'b0;
      cyc(6);
      for (int i = 0; i < 8; i++) frame($urandom, 16 + 16 * (i % 2));
      $display("test random commands done");
      foreach (bad[k]) frame($urandom, bad[k]);
      $display("test bad lengths done");
      fault(24, 4);
      m_tw = 1'b1;
      host.peek(b);
      chk({15'h0, b}, 16'h0001, "first bit");
      frame(32'h0001, 16);
      $display("test thermal done");
      frame(32'h200C, 16);
      fault(18, 4);
      m_flg[0] = 1'b1;
      m_drv[1] = 1'b0;
      chk(pins(), {4'h0, m_drv}, "oc latch");
      frame(32'h000C, 16);
      fault(13, 4);
      chk(pins(), {4'h0, m_drv}, "oc unarmed");
      $display("test overcurrent done");
      frame(32'h4061, 16);
      fault(8, 12);
      m_flg[1] = 1'b1;
      m_drv[5] = 1'b0;
      chk(pins(), {4'h0, m_drv}, "ul latch");
      $display("test underload done");
      frame(32'h8007, 16);
      flt[26] <= 1'b1;
      cyc(6);
      chk(pins(), 16'h0000, "ov off");
      flt[26] <= 1'b0;
      m_flg[2] = 1'b1;
      cyc(6);
      frame(32'h0006, 16);
      fault(26, 4);
      fault(25, 5);
      chk(pins(), {4'h0, m_drv}, "supply back");
      frame(32'h1FFE, 16);
      $display("test supply done");
      wake_i <= 1'b0;
      cyc(6);
      chk(pins(), 16'h0000, "sleep");
      host.xfer(32'h0FFE, 16, rx_dump);
      chk(rx_dump[15:0], 16'h0000, "sleep status");
      wake_i <= 1'b1;
      cyc(6);
      {m_flg, m_drv, m_tw} = 16'h0000;
      frame(32'h0000, 16);
      $display("test sleep done");
      tally_and_finish();
   end

   initial begin
      cyc(20000);
      mismatches++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
